// *** ptfc_top.sv ***
// Purpose: Pixel widening, frame timing, VCOM, amplifier, booster and VPP control.
// Assumes: fosc is clk_i; host selects page 0 before any access here.
// Notes:   Partial mode shares the normal timing set; idle keeps its own.

module ptfc_top #(
  parameter int unsigned ACTIVE_LINES = 432
) (
  input  wire logic                  clk_i,          // 100 MHz oscillator clock
  input  wire logic                  rst_i,          // Synchronous reset, high
  input  wire logic                  page_zero_i,    // Command page 0 selected
  input  wire logic                  reg_wr_i,       // Parameter write strobe
  input  wire logic                  reg_rd_i,       // Parameter read strobe
  input  wire logic [7:0]            reg_addr_i,     // Command code
  input  wire logic [7:0]            reg_wdata_i,    // Parameter write byte
  output logic      [7:0]            reg_rdata_o,    // Parameter read byte
  output logic                       reg_rvalid_o,   // Read byte valid
  input  wire ptfc_pkg::ptfc_mode_e  mode_i,         // Display power mode
  input  wire logic                  pix_valid_i,    // 16-bit pixel valid
  input  wire ptfc_pkg::ptfc_rgb565_s pix_i,         // 16-bit pixel
  output logic                       pix_valid_o,    // 18-bit word valid
  output ptfc_pkg::ptfc_rgb666_s     pix_o,          // 18-bit memory word
  output logic                       div_tick_o,     // Divided clock enable
  output logic                       line_start_o,   // First tick of a line
  output logic                       frame_start_o,  // First line of a frame
  output logic                       active_o,       // Active lines in progress
  output logic                       vcom_pol_o,     // VCOM polarity
  output ptfc_pkg::ptfc_scale_e      gamma_scale_o,  // Gamma amplifier current
  output ptfc_pkg::ptfc_scale_e      source_scale_o, // Source amplifier current
  output logic                       amp_halt_o,     // Amplifiers and boosters off
  output logic      [1:0]            booster_clk_o,  // Booster 1 and 2/3 pulses
  output logic      [2:0]            vpp_level_o,    // Internal VPP step code
  output logic                       vpp_external_o  // External VPP selected
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  typedef enum logic [1:0] {PH_BACK, PH_ACTIVE, PH_FRONT} ptfc_phase_e;

  logic [7:0]                  regs_ff [ptfc_pkg::REG_CNT];
  logic [ptfc_pkg::REG_CNT-1:0] hit;
  logic [7:0]                  rd_terms [ptfc_pkg::REG_CNT];
  logic [7:0]                  rd_mux;

  // Decode and store each byte; reserved bits never store
  for (genvar i = 0; i < ptfc_pkg::REG_CNT; i++) begin : g_reg
    assign hit[i]      = page_zero_i && (reg_addr_i == ptfc_pkg::REG_ADDR[i]);
    assign rd_terms[i] = hit[i] ? regs_ff[i] : 8'h00;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        regs_ff[i] <= ptfc_pkg::REG_RST[i];
      end else if (reg_wr_i && hit[i]) begin
        regs_ff[i] <= reg_wdata_i & ptfc_pkg::REG_MASK[i];
      end
    end
  end

  // Unmapped codes read as zero
  always_comb begin
    rd_mux = 8'h00;
    for (int j = 0; j < ptfc_pkg::REG_CNT; j++) begin
      rd_mux = rd_mux | rd_terms[j];
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o  <= reg_rd_i ? rd_mux : reg_rdata_o;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ****************************************************************
  // Mode selection
  // ****************************************************************
  wire        is_idle    = (mode_i == ptfc_pkg::MODE_IDLE);
  wire        is_partial = (mode_i == ptfc_pkg::MODE_PARTIAL);
  // Idle has its own timing set; partial shares normal's
  wire [7:0]  invdiv_sel = is_idle ? regs_ff[ptfc_pkg::IDX_I_INVDIV]
                                   : regs_ff[ptfc_pkg::IDX_N_INVDIV];
  wire [4:0]  line_code  = is_idle ? regs_ff[ptfc_pkg::IDX_I_LINE][4:0]
                                   : regs_ff[ptfc_pkg::IDX_N_LINE][4:0];
  wire [7:0]  bp_code    = is_idle ? regs_ff[ptfc_pkg::IDX_I_BP]
                                   : regs_ff[ptfc_pkg::IDX_N_BP];
  wire [7:0]  fp_code    = is_idle ? regs_ff[ptfc_pkg::IDX_I_FP]
                                   : regs_ff[ptfc_pkg::IDX_N_FP];
  // Amplifier and booster settings have three independent sets; VPP has one
  wire [7:0]  amp_reg    = is_idle    ? regs_ff[ptfc_pkg::IDX_I_AMP] :
                           is_partial ? regs_ff[ptfc_pkg::IDX_P_AMP] :
                                        regs_ff[ptfc_pkg::IDX_N_AMP];
  wire [7:0]  boost_reg  = is_idle    ? regs_ff[ptfc_pkg::IDX_I_BOOST] :
                           is_partial ? regs_ff[ptfc_pkg::IDX_P_BOOST] :
                                        regs_ff[ptfc_pkg::IDX_N_BOOST];
  wire [2:0]  amp_code   = amp_reg[2:0];
  wire [1:0]  div_code   = invdiv_sel[ptfc_pkg::DIV_LSB +: 2];
  wire        line_inv   = invdiv_sel[ptfc_pkg::INV_BIT];
  wire [1:0]  expand_fmt = regs_ff[ptfc_pkg::IDX_EXPAND][ptfc_pkg::EXPAND_LSB +: 2];

  // ****************************************************************
  // Divider and line timing
  // ****************************************************************
  logic [2:0] div_cnt_ff;
  logic [7:0] clk_cnt_ff;
  // A forbidden short code is held at the shortest legal line
  wire  [4:0] line_eff   = (line_code < ptfc_pkg::LINE_MIN_CODE) ? ptfc_pkg::LINE_MIN_CODE
                                                                 : line_code;
  wire  [7:0] line_len   = {3'h0, line_eff} + ptfc_pkg::LINE_OFFSET;
  wire  [2:0] div_mask   = 3'(({1'b0, 3'h1} << div_code) - 4'h1);
  wire        div_tick   = ((div_cnt_ff & div_mask) == div_mask);
  wire        line_end   = div_tick && (clk_cnt_ff >= line_len - 8'h01);

  // Free-running prescaler; mask picks the ratio
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_ff <= 3'h0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 3'h1;
    end
  end

  // Clocks-per-line counter advances only on divided ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_cnt_ff <= 8'h00;
    end else if (div_tick) begin
      clk_cnt_ff <= line_end ? 8'h00 : clk_cnt_ff + 8'h01;
    end
  end

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  ptfc_phase_e phase_ff;
  ptfc_phase_e nxt_phase;
  logic [8:0]  line_cnt_ff;
  logic [8:0]  phase_len;
  logic        vcom_ff;

  // Porch decode; forbidden codes fall back to the code-zero length
  function automatic logic [8:0] porch_lines(input logic [7:0] code);
    logic [7:0] n;
    n = ptfc_pkg::PORCH_ADD;
    if (code <= ptfc_pkg::PORCH_LO_MAX) begin
      n = code + ptfc_pkg::PORCH_ADD;
    end else if (code >= ptfc_pkg::PORCH_HI_MIN && code <= ptfc_pkg::PORCH_HI_MAX) begin
      n = code - ptfc_pkg::PORCH_SUB;
    end
    return {1'b0, n};
  endfunction : porch_lines

  wire [8:0] bp_len   = porch_lines(bp_code);
  wire [8:0] fp_len   = porch_lines(fp_code);
  wire       last_ln  = line_end && (line_cnt_ff >= phase_len - 9'h001);
  wire       frame_end = last_ln && (phase_ff == PH_FRONT);

  // Length of the current phase and the next phase
  always_comb begin
    phase_len = bp_len;
    nxt_phase = phase_ff;
    unique case (phase_ff)
      PH_BACK: begin
        phase_len = bp_len;
        nxt_phase = PH_ACTIVE;
      end
      PH_ACTIVE: begin
        phase_len = 9'(ACTIVE_LINES);
        nxt_phase = PH_FRONT;
      end
      PH_FRONT: begin
        phase_len = fp_len;
        nxt_phase = PH_BACK;
      end
    endcase
  end

  // Back porch, active, front porch, one line per line end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_ff    <= PH_BACK;
      line_cnt_ff <= 9'h000;
    end else if (last_ln) begin
      phase_ff    <= nxt_phase;
      line_cnt_ff <= 9'h000;
    end else if (line_end) begin
      line_cnt_ff <= line_cnt_ff + 9'h001;
    end
  end

  // VCOM flips each line or each frame, chosen per mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vcom_ff <= 1'b0;
    end else if (line_inv ? line_end : frame_end) begin
      vcom_ff <= ~vcom_ff;
    end
  end

  // Timing strobes, registered so the panel side sees clean pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_tick_o    <= 1'b0;
      line_start_o  <= 1'b0;
      frame_start_o <= 1'b0;
      active_o      <= 1'b0;
    end else begin
      div_tick_o    <= div_tick;
      line_start_o  <= line_end;
      frame_start_o <= frame_end;
      active_o      <= (phase_ff == PH_ACTIVE);
    end
  end
  assign vcom_pol_o = vcom_ff;

  // ****************************************************************
  // Pixel expansion 16 to 18 bits
  // ****************************************************************
  ptfc_pkg::ptfc_rgb666_s pix_exp;
  wire r_eq_g = (pix_i.r == pix_i.g[5:1]);
  wire b_eq_g = (pix_i.b == pix_i.g[5:1]);

  always_comb begin
    pix_exp.g = pix_i.g;
    pix_exp.r = {pix_i.r, 1'b0};
    pix_exp.b = {pix_i.b, 1'b0};
    unique case (expand_fmt)
      2'h0: begin
        pix_exp.r = (pix_i.r == ptfc_pkg::RB_FULL) ? ptfc_pkg::RB_SAT_HI
                                                   : {pix_i.r, 1'b0};
        pix_exp.b = (pix_i.b == ptfc_pkg::RB_FULL) ? ptfc_pkg::RB_SAT_HI
                                                   : {pix_i.b, 1'b0};
      end
      2'h1: begin
        pix_exp.r = (pix_i.r == ptfc_pkg::RB_ZERO) ? ptfc_pkg::RB_SAT_LO
                                                   : {pix_i.r, 1'b1};
        pix_exp.b = (pix_i.b == ptfc_pkg::RB_ZERO) ? ptfc_pkg::RB_SAT_LO
                                                   : {pix_i.b, 1'b1};
      end
      2'h2: begin
        pix_exp.r = {pix_i.r, pix_i.r[4]};
        pix_exp.b = {pix_i.b, pix_i.b[4]};
      end
      2'h3: begin
        // Matching green borrows its LSB so greys stay neutral
        pix_exp.r = {pix_i.r, r_eq_g ? pix_i.g[0] : pix_i.r[4]};
        pix_exp.b = {pix_i.b, b_eq_g ? pix_i.g[0] : pix_i.b[4]};
      end
    endcase
  end

  // One stage of latency, no stall: the memory side always accepts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_o       <= '0;
      pix_valid_o <= 1'b0;
    end else begin
      pix_o       <= pix_valid_i ? pix_exp : pix_o;
      pix_valid_o <= pix_valid_i;
    end
  end

  // ****************************************************************
  // Amplifier current, boosters and VPP
  // ****************************************************************
  ptfc_pkg::ptfc_scale_e gam_nxt;
  ptfc_pkg::ptfc_scale_e src_nxt;
  wire amp_halt = (amp_code == 3'h0);

  // Gamma and source current scaling
  always_comb begin
    gam_nxt = ptfc_pkg::SCALE_HALT;
    src_nxt = ptfc_pkg::SCALE_HALT;
    unique case (amp_code)
      3'h0: begin gam_nxt = ptfc_pkg::SCALE_HALT; src_nxt = ptfc_pkg::SCALE_HALT; end
      3'h1: begin gam_nxt = ptfc_pkg::SCALE_FULL; src_nxt = ptfc_pkg::SCALE_FULL; end
      3'h2: begin gam_nxt = ptfc_pkg::SCALE_FULL; src_nxt = ptfc_pkg::SCALE_075;  end
      3'h3: begin gam_nxt = ptfc_pkg::SCALE_FULL; src_nxt = ptfc_pkg::SCALE_050;  end
      3'h4: begin gam_nxt = ptfc_pkg::SCALE_075;  src_nxt = ptfc_pkg::SCALE_FULL; end
      3'h5: begin gam_nxt = ptfc_pkg::SCALE_075;  src_nxt = ptfc_pkg::SCALE_075;  end
      3'h6: begin gam_nxt = ptfc_pkg::SCALE_075;  src_nxt = ptfc_pkg::SCALE_050;  end
      3'h7: begin gam_nxt = ptfc_pkg::SCALE_050;  src_nxt = ptfc_pkg::SCALE_050;  end
    endcase
  end

  // Registered power controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gamma_scale_o  <= ptfc_pkg::SCALE_HALT;
      source_scale_o <= ptfc_pkg::SCALE_HALT;
      amp_halt_o     <= 1'b1;
      vpp_level_o    <= 3'h0;
      vpp_external_o <= 1'b0;
    end else begin
      gamma_scale_o  <= gam_nxt;
      source_scale_o <= src_nxt;
      amp_halt_o     <= amp_halt;
      vpp_level_o    <= regs_ff[ptfc_pkg::IDX_VPP][2:0];
      vpp_external_o <= (regs_ff[ptfc_pkg::IDX_VPP][2:0] == ptfc_pkg::VPP_EXT_CODE);
    end
  end

  // Booster rate by phase accumulator: step quarters per tick against
  // four line lengths, so fractional rates like 1.5x need no extra clock
  wire [10:0] boost_den = {1'b0, line_len, 2'b00};
  for (genvar k = 0; k < 2; k++) begin : g_boost
    logic [10:0] acc_ff;
    logic        pulse_ff;
    wire  [2:0]  code = boost_reg[(k == 0 ? ptfc_pkg::B1_LSB : ptfc_pkg::B23_LSB) +: 3];
    wire  [10:0] sum  = acc_ff + {5'h00, ptfc_pkg::BOOST_STEP[code]};
    wire         wrap = (sum >= boost_den);
    // Each pulse has its own flop so no output bit has two writers
    always_ff @(posedge clk_i) begin
      if (rst_i || amp_halt) begin
        acc_ff   <= 11'h000;
        pulse_ff <= 1'b0;
      end else begin
        acc_ff   <= div_tick ? (wrap ? sum - boost_den : sum) : acc_ff;
        pulse_ff <= div_tick && wrap;
      end
    end
    assign booster_clk_o[k] = pulse_ff;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [7:0] ticks_ff;
  logic       len_chg_ff;
  logic [3:0] gap_ff;
  logic [3:0] run3_ff;
  // Ticks per line; a mid-line length change voids that line's check,
  // since the counter may already stand past the new end
  always_ff @(posedge clk_i) begin
    if (rst_i || line_end) begin
      ticks_ff   <= 8'h00;
      len_chg_ff <= 1'b0;
    end else begin
      ticks_ff   <= div_tick ? ticks_ff + 8'h01 : ticks_ff;
      len_chg_ff <= len_chg_ff || $changed(line_len);
    end
  end

  // Cycles since the last divided tick, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || div_tick) begin
      gap_ff <= 4'h0;
    end else if (gap_ff != 4'hF) begin
      gap_ff <= gap_ff + 4'h1;
    end
  end

  // Cycles the divide-by-8 code has been in force, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || div_code != 2'h3) begin
      run3_ff <= 4'h0;
    end else if (run3_ff != 4'hF) begin
      run3_ff <= run3_ff + 4'h1;
    end
  end

  expand_zero_a: assert property (pix_valid_i && expand_fmt == 2'h0 &&
    pix_i.r == 5'h1F |=> pix_o.r == 6'h3E) else $error("format 00 red saturation wrong");
  expand_one_a: assert property (pix_valid_i && expand_fmt == 2'h1 &&
    pix_i.b == 5'h00 |=> pix_o.b == 6'h01) else $error("format 01 blue floor wrong");
  expand_msb_a: assert property (pix_valid_i && expand_fmt == 2'h2
    |=> pix_o.r == {$past(pix_i.r), $past(pix_i.r[4])} && pix_o.g == $past(pix_i.g))
    else $error("format 10 msb copy wrong");
  expand_cmp_a: assert property (pix_valid_i && expand_fmt == 2'h3 &&
    pix_i.b == pix_i.g[5:1] |=> pix_o.b[0] == $past(pix_i.g[0]))
    else $error("format 11 equal colour lsb wrong");
  vcom_line_a: assert property (line_end && line_inv |=> vcom_pol_o != $past(vcom_pol_o))
    else $error("line inversion missed a flip");
  div_ratio_a: assert property (div_tick && div_code == 2'h3 && run3_ff >= 4'h8
    |-> gap_ff == 4'h7) else $error("divide by 8 spacing wrong");
  line_len_a: assert property (line_end && !len_chg_ff && $stable(line_len)
    |-> ticks_ff + 8'h01 == line_len) else $error("line length count wrong");
  porch_hold_a: assert property (phase_ff == PH_BACK && line_end &&
    line_cnt_ff + 9'h001 < bp_len |=> phase_ff == PH_BACK) else $error("back porch ended early");
  amp_halt_a: assert property (amp_code == 3'h0 |=> amp_halt_o && booster_clk_o == 2'b00)
    else $error("halt did not stop boosters");
  vpp_ext_a: assert property (regs_ff[ptfc_pkg::IDX_VPP][2:0] == 3'h7 |=> ##[0:1] vpp_external_o)
    else $error("external vpp not flagged");

  frame_seen_c: cover property (frame_start_o);
  booster_seen_c: cover property (booster_clk_o[0] ##[1:600] booster_clk_o[0]);
  idle_line_c: cover property (is_idle && line_end);

endmodule : ptfc_top

// *** ptfc_pkg.sv ***
// Purpose: Shared constants and types for the panel timing and format block.
// Assumes: One byte-wide command-parameter port, page 0 decoded by the host.
// Notes:   Register tables are indexed 0..15 in address order.

// ****************************************************************
// Package
// ****************************************************************
package ptfc_pkg;

  localparam int unsigned REG_CNT = 16;

  // Register indices, in address order
  localparam int unsigned IDX_EXPAND     = 0;
  localparam int unsigned IDX_N_INVDIV   = 1;
  localparam int unsigned IDX_N_LINE     = 2;
  localparam int unsigned IDX_N_BP       = 3;
  localparam int unsigned IDX_N_FP       = 4;
  localparam int unsigned IDX_I_INVDIV   = 5;
  localparam int unsigned IDX_I_LINE     = 6;
  localparam int unsigned IDX_I_BP       = 7;
  localparam int unsigned IDX_I_FP       = 8;
  localparam int unsigned IDX_N_AMP      = 9;
  localparam int unsigned IDX_N_BOOST    = 10;
  localparam int unsigned IDX_P_AMP      = 11;
  localparam int unsigned IDX_P_BOOST    = 12;
  localparam int unsigned IDX_I_AMP      = 13;
  localparam int unsigned IDX_I_BOOST    = 14;
  localparam int unsigned IDX_VPP        = 15;

  // Command codes, writable bits and reset values per register index
  localparam logic [7:0] REG_ADDR [REG_CNT] = '{
    8'h6B, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76,
    8'h77, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h7F, 8'h86};
  localparam logic [7:0] REG_MASK [REG_CNT] = '{
    8'h31, 8'h13, 8'h1F, 8'hFF, 8'hFF, 8'h13, 8'h1F, 8'hFF,
    8'hFF, 8'h07, 8'h77, 8'h07, 8'h77, 8'h07, 8'h77, 8'h07};
  localparam logic [7:0] REG_RST [REG_CNT] = '{
    8'h00, 8'h00, 8'h0B, 8'h00, 8'h00, 8'h00, 8'h0B, 8'h00,
    8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h03};

  // Field positions
  localparam int unsigned EXPAND_LSB = 4;
  localparam int unsigned INV_BIT    = 4;
  localparam int unsigned DIV_LSB    = 0;
  localparam int unsigned B1_LSB     = 0;
  localparam int unsigned B23_LSB    = 4;

  // Line length and porch coding
  localparam logic [4:0] LINE_MIN_CODE = 5'h0B;
  localparam logic [7:0] LINE_OFFSET   = 8'h74;
  localparam logic [7:0] PORCH_LO_MAX  = 8'h7F;
  localparam logic [7:0] PORCH_HI_MIN  = 8'h82;
  localparam logic [7:0] PORCH_HI_MAX  = 8'h8E;
  localparam logic [7:0] PORCH_ADD     = 8'h0F;
  localparam logic [7:0] PORCH_SUB     = 8'h80;

  // Expansion corner values
  localparam logic [4:0] RB_FULL   = 5'h1F;
  localparam logic [5:0] RB_SAT_HI = 6'h3E;
  localparam logic [4:0] RB_ZERO   = 5'h00;
  localparam logic [5:0] RB_SAT_LO = 6'h01;

  // Booster rate in quarters of line frequency, per code
  localparam logic [5:0] BOOST_STEP [8] = '{
    6'h01, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h20};
  localparam logic [2:0] VPP_EXT_CODE = 3'h7;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_PARTIAL, MODE_IDLE} ptfc_mode_e;
  typedef enum logic [1:0] {SCALE_HALT, SCALE_FULL, SCALE_075, SCALE_050} ptfc_scale_e;

  typedef struct packed {
    logic [4:0] r;
    logic [5:0] g;
    logic [4:0] b;
  } ptfc_rgb565_s;

  typedef struct packed {
    logic [5:0] r;
    logic [5:0] g;
    logic [5:0] b;
  } ptfc_rgb666_s;

endpackage : ptfc_pkg

// *** ptfc_host.sv ***
// Purpose: Host model on the command-parameter port.
// Assumes: Strobes last one clock and change on the falling edge.
// Notes:   Idle write data shows the inverse of the last byte.
// ****************
// Host model
// ****************
module ptfc_host (
  input  wire logic       clk_i,       // Clock
  input  wire logic [7:0] rdata_i,     // Read byte
  input  wire logic       rvalid_i,    // Read byte valid
  output logic            page_zero_o, // Page 0 selected
  output logic            wr_o,        // Write strobe
  output logic            rd_o,        // Read strobe
  output logic      [7:0] addr_o,      // Command code
  output logic      [7:0] wdata_o      // Write byte
);
  // Page 0 is chosen before any access
  initial begin
    page_zero_o = 1'b1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end

  // Callers hand over only legal line and porch codes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask : wr

  // Byte is taken one cycle after the strobe, marked bad without valid
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hEE;
  endtask : rd
endmodule : ptfc_host

// *** ptfc_top_tb.sv ***
// Purpose: Self-checking bench for the panel timing and format block.
// Assumes: Host model owns the register port; bench drives pixels and mode.
// Notes:   Four active lines keep frame checks short.
module ptfc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0]  f;
    logic [4:0]  r;
    logic [5:0]  g;
    logic [4:0]  b;
    logic [17:0] o;
  } ptfc_row_s;
  localparam ptfc_row_s ROWS [8] = '{
    '{2'h0, 5'h1F, 6'h2A, 5'h03, {6'h3E, 6'h2A, 6'h06}},
    '{2'h1, 5'h00, 6'h15, 5'h10, {6'h01, 6'h15, 6'h21}},
    '{2'h2, 5'h10, 6'h3F, 5'h0F, {6'h21, 6'h3F, 6'h1E}},
    '{2'h3, 5'h0A, 6'h15, 5'h0A, {6'h15, 6'h15, 6'h15}},
    '{2'h3, 5'h1F, 6'h00, 5'h1F, {6'h3F, 6'h00, 6'h3F}},
    '{2'h3, 5'h0A, 6'h14, 5'h11, {6'h14, 6'h14, 6'h23}},
    '{2'h3, 5'h11, 6'h15, 5'h0A, {6'h23, 6'h15, 6'h15}},
    '{2'h3, 5'h10, 6'h00, 5'h01, {6'h21, 6'h00, 6'h02}}};
  localparam logic [4:0] AMP_EXP [8] = '{5'h10, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A, 5'h0B, 5'h0F};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pix_valid_i = 1'b0;
  ptfc_pkg::ptfc_mode_e mode_i = ptfc_pkg::MODE_NORMAL;
  ptfc_pkg::ptfc_rgb565_s pix_i = '0;
  ptfc_pkg::ptfc_rgb666_s pix_o;
  ptfc_pkg::ptfc_scale_e gamma_scale_o, source_scale_o;
  logic pg, wr, rd, reg_rvalid_o, pix_valid_o, line_start_o, frame_start_o;
  logic amp_halt_o, vpp_external_o, div_tick_o, active_o, vcom_pol_o;
  logic [7:0] addr, wdata, reg_rdata_o;
  logic [1:0] booster_clk_o;
  logic [2:0] vpp_level_o;
  int n_fail = 0;
  int n_checks = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  ptfc_host u_host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
    .page_zero_o(pg), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

  ptfc_top #(.ACTIVE_LINES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .page_zero_i(pg),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .mode_i(mode_i),
    .pix_valid_i(pix_valid_i), .pix_i(pix_i), .pix_valid_o(pix_valid_o), .pix_o(pix_o),
    .div_tick_o(div_tick_o), .line_start_o(line_start_o), .frame_start_o(frame_start_o),
    .active_o(active_o), .vcom_pol_o(vcom_pol_o), .gamma_scale_o(gamma_scale_o),
    .source_scale_o(source_scale_o), .amp_halt_o(amp_halt_o),
    .booster_clk_o(booster_clk_o), .vpp_level_o(vpp_level_o),
    .vpp_external_o(vpp_external_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Cycles between pulses; the first two spans are skipped as settings settle
  task automatic span(input logic sel, input int exp);
    int n;
    n = 0;
    for (int p = 0; p < 3; p++) begin
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while ((sel ? frame_start_o : line_start_o) !== 1'b1 && n < 4000);
    end
    chk(n, exp);
  endtask : span

  task automatic results;
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    n_fail++;
    results();
  end

  // Main sequence
  initial begin
    logic [7:0] d, q;
    int c1, c23;
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 16; i++) begin
      u_host.rd(ptfc_pkg::REG_ADDR[i], q);
      chk(q, ptfc_pkg::REG_RST[i]);
      d = (ptfc_pkg::REG_MASK[i] == 8'hFF) ? 8'h8E : 8'hFF;
      u_host.wr(ptfc_pkg::REG_ADDR[i], d);
      u_host.rd(ptfc_pkg::REG_ADDR[i], q);
      chk(q, d & ptfc_pkg::REG_MASK[i]);
    end
    u_host.page_zero_o = 1'b0;
    u_host.wr(8'h86, 8'h00);
    u_host.page_zero_o = 1'b1;
    u_host.rd(8'h86, q);
    chk(q, 8'h07);
    u_host.rd(8'h80, q);
    chk(q, 8'h00);
    // Table of pixel cases covering every expansion format and every compare outcome
    foreach (ROWS[k]) begin
      u_host.wr(8'h6B, {2'b00, ROWS[k].f, 4'h0});
      pix_valid_i = 1'b1;
      pix_i = {ROWS[k].r, ROWS[k].g, ROWS[k].b};
      @(negedge clk_i);
      pix_valid_i = 1'b0;
      chk({pix_valid_o, pix_o}, {1'b1, ROWS[k].o});
    end
    for (int c = 0; c < 8; c++) begin
      u_host.wr(8'h7A, 8'(c));
      u_host.wr(8'h86, 8'(c));
      @(negedge clk_i);
      chk({amp_halt_o, gamma_scale_o, source_scale_o}, AMP_EXP[c]);
      chk({vpp_external_o, vpp_level_o}, {(c == 7), 3'(c)});
    end
    u_host.wr(8'h7C, 8'h01);
    mode_i = ptfc_pkg::MODE_PARTIAL;
    @(negedge clk_i);
    chk({amp_halt_o, gamma_scale_o, source_scale_o}, 5'h05);
    u_host.wr(8'h7E, 8'h00);
    mode_i = ptfc_pkg::MODE_IDLE;
    @(negedge clk_i);
    chk({amp_halt_o, gamma_scale_o, source_scale_o}, 5'h10);
    mode_i = ptfc_pkg::MODE_NORMAL;
    u_host.wr(8'h71, 8'h1F);
    for (int v = 0; v < 4; v++) begin
      u_host.wr(8'h70, 8'(v));
      span(1'b0, 147 << v);
      c1 = 0;
      repeat (64) begin
        @(negedge clk_i);
        c1 += int'(div_tick_o === 1'b1);
      end
      chk(c1, 64 >> v);
    end
    u_host.wr(8'h70, 8'h00);
    u_host.wr(8'h71, 8'h0B);
    span(1'b0, 127);
    u_host.wr(8'h7E, 8'h01);
    mode_i = ptfc_pkg::MODE_IDLE;
    span(1'b0, 147 << 3);
    mode_i = ptfc_pkg::MODE_NORMAL;
    u_host.wr(8'h72, 8'h00);
    u_host.wr(8'h73, 8'h82);
    span(1'b1, 21 * 127);
    repeat (15 * 127) @(negedge clk_i);
    chk(active_o, 1'b0);
    @(negedge clk_i);
    chk(active_o, 1'b1);
    u_host.wr(8'h7B, 8'h27);
    span(1'b0, 127);
    c1 = 0;
    c23 = 0;
    repeat (4 * 127) begin
      @(negedge clk_i);
      c1 += int'(booster_clk_o[0] === 1'b1);
      c23 += int'(booster_clk_o[1] === 1'b1);
    end
    chk(c1, 32);
    chk(c23, 4);
    u_host.wr(8'h70, 8'h10);
    span(1'b0, 127);
    d[0] = vcom_pol_o;
    repeat (126) @(negedge clk_i);
    chk(vcom_pol_o, d[0]);
    @(negedge clk_i);
    chk(vcom_pol_o, !d[0]);
    results();
  end
endmodule : ptfc_top_tb
